// ---- rtl/dss_apb_regs.sv ----
// apb slave holding the control, acknowledge and port registers
`timescale 1ns/1ns
`default_nettype none
`include "dss_params.svh"

module dss_apb_regs (
	input  wire logic                    ref_clk,
	input  wire logic                    rst_n,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [`DSS_ADDR_W-1:0]  paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	dss_if.regs                          bus
);
	import dss_pkg::*;

	logic                    next_pready;
	logic [31:0]             next_prdata;
	logic                    next_pslverr;
	dss_ctrl_t               next_ctrl;
	logic [`DSS_PORT_W-1:0]  next_port;
	logic                    next_ack;
	logic                    wr_take;

	// one wait state so read data leaves a flop
	always_comb begin
		next_pready  = psel & penable & ~pready;
		next_prdata  = prdata;
		next_pslverr = pslverr;
		next_ctrl    = bus.ctrl;
		next_port    = bus.port_reg;
		next_ack     = 1'b0;
		wr_take      = psel & penable & pready & pwrite;
		if (next_pready) begin
			next_pslverr = 1'b0;
			case (paddr)
				`DSS_OFS_CTRL:   next_prdata = {25'h000_0000, bus.ctrl};
				`DSS_OFS_STATUS: next_prdata = {28'h000_0000, bus.status};
				`DSS_OFS_ACK:    next_prdata = 32'h0000_0000;
				`DSS_OFS_PORT:   next_prdata = {24'h00_0000, bus.port_reg};
				default: begin
					next_prdata  = 32'h0000_0000;
					next_pslverr = 1'b1;
				end
			endcase
		end
		if (wr_take) begin
			case (paddr)
				`DSS_OFS_CTRL: next_ctrl = dss_ctrl_t'(pwdata[`DSS_CTRL_W-1:0]);
				`DSS_OFS_ACK:  next_ack  = pwdata[`DSS_ACK_BIT];
				`DSS_OFS_PORT: next_port = pwdata[`DSS_PORT_W-1:0];
				default: ;
			endcase
		end
		// restart brings every setting back to default; pin latch lives elsewhere
		if (bus.soft_rst) begin
			next_ctrl = dss_ctrl_t'(`DSS_CTRL_RST);
			next_port = `DSS_PORT_RST;
			next_ack  = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pready        <= 1'b0;
			prdata        <= 32'h0000_0000;
			pslverr       <= 1'b0;
			bus.ctrl      <= dss_ctrl_t'(`DSS_CTRL_RST);
			bus.port_reg  <= `DSS_PORT_RST;
			bus.ack_pulse <= 1'b0;
		end else begin
			pready        <= next_pready;
			prdata        <= next_prdata;
			pslverr       <= next_pslverr;
			bus.ctrl      <= next_ctrl;
			bus.port_reg  <= next_port;
			bus.ack_pulse <= next_ack;
		end
	end
endmodule

`default_nettype wire

// ---- rtl/dss_if.sv ----
// carrier between the register file and the sequencer core
`timescale 1ns/1ns
`default_nettype none
`include "dss_params.svh"

interface dss_if;
	dss_pkg::dss_ctrl_t             ctrl;
	logic                           ack_pulse;
	logic [`DSS_PORT_W-1:0]         port_reg;
	logic                           soft_rst;
	logic [`DSS_STATUS_W-1:0]       status;

	modport regs (output ctrl, output ack_pulse, output port_reg, input soft_rst, input status);
	modport seq  (input ctrl, input ack_pulse, input port_reg, output soft_rst, output status);
endinterface

`default_nettype wire

// ---- rtl/dss_params.svh ----
// register offsets, field positions and reset values of the deep stop sequencer
`ifndef DSS_PARAMS_SVH
`define DSS_PARAMS_SVH

`define DSS_ADDR_W        12
`define DSS_OFS_CTRL      12'h000
`define DSS_OFS_STATUS    12'h004
`define DSS_OFS_ACK       12'h008
`define DSS_OFS_PORT      12'h00C

`define DSS_CTRL_W        7
`define DSS_CTRL_RST      7'h00
`define DSS_PORT_W        8
`define DSS_PORT_RST      8'h00
`define DSS_STATUS_W      4

`define DSS_ACK_BIT       0
`define DSS_ST_HOLD_BIT   0
`define DSS_ST_DEEP_BIT   1
`define DSS_ST_LIGHT_BIT  2
`define DSS_ST_WOKE_BIT   3

`endif

// ---- rtl/dss_pkg.sv ----
// types shared by the deep stop sequencer and its register file
package dss_pkg;

	// only two stop modes exist; there is no lowest-voltage mode
	typedef enum logic [1:0] {
		st_run,
		st_light,
		st_deep,
		st_wake
	} dss_mode_t;

	typedef struct packed {
		logic irq_active_high;
		logic irq_pullup_enable;
		logic xosc_in_stop;
		logic deep_stop_select;
		logic low_volt_in_stop_enable;
		logic low_volt_detect_enable;
		logic stop_allow;
	} dss_ctrl_t;

endpackage

// ---- rtl/dss_sequencer.sv ----
// stop mode entry, residence and wake-up sequencer with pin latching
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "dss_params.svh"

// How it works
// - stop instruction with stop not allowed gives an illegal-opcode reset, no stop.
// - deep stop entered only with deep select and stop allow set, detector off in stop.
// - detector enabled globally and in stop forces light stop, deep select ignored.
// - deep stop powers off core and peripherals, keeps ram, regulator and converter standby.
// - pins latched at deep entry, held until software writes one to release ack.
// - deep stop left only by reset pin, interrupt pin or wake-up timer.
// - interrupt pin read as active low in deep stop, whatever polarity was set.
// - deep stop wake restarts the chip as from power-on, pins stay latched.
// - light stop turns the clock generator off, crystal may keep running if chosen.
// - only deep and light stop modes exist, no lowest-voltage mode.
// - detector runs in stop only when both its enables are set.
module dss_sequencer (
	input  wire logic                    ref_clk,
	input  wire logic                    rst_n,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [`DSS_ADDR_W-1:0]  paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    stop_instr,
	input  wire logic                    reset_pin_n,
	input  wire logic                    irq_pin,
	input  wire logic                    rti_wakeup,
	output dss_pkg::dss_mode_t           mode,
	output logic                         illegal_reset,
	output logic                         sys_restart,
	output logic                         core_power_on,
	output logic                         periph_power_on,
	output logic                         ram_power_on,
	output logic                         regulator_standby,
	output logic                         adc_standby,
	output logic                         clkgen_on,
	output logic                         xosc_on,
	output logic                         lvd_active,
	output logic                         irq_pullup_on,
	output logic                         pin_hold,
	output logic      [`DSS_PORT_W-1:0]  port_pins
);
	import dss_pkg::*;

	dss_if bus ();

	dss_apb_regs u_regs (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.bus     (bus)
	);

	// pin synchronisers
	logic                    rpin_meta;
	logic                    rpin_sync;
	logic                    irq_meta;
	logic                    irq_sync;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rpin_meta <= 1'b1;
			rpin_sync <= 1'b1;
			irq_meta  <= 1'b1;
			irq_sync  <= 1'b1;
		end else begin
			rpin_meta <= reset_pin_n;
			rpin_sync <= rpin_meta;
			irq_meta  <= irq_pin;
			irq_sync  <= irq_meta;
		end
	end

	logic                    ctl_allow;
	logic                    ctl_low_volt_detect_enable;
	logic                    ctl_lvse;
	logic                    ctl_deep;
	logic                    ctl_xosc;
	logic                    lv_in_stop;
	logic                    irq_asserted;
	logic                    pin_reset;
	logic                    wake_deep;
	logic                    wake_light;

	assign ctl_allow  = bus.ctrl.stop_allow;
	assign ctl_low_volt_detect_enable   = bus.ctrl.low_volt_detect_enable;
	assign ctl_lvse   = bus.ctrl.low_volt_in_stop_enable;
	assign ctl_deep   = bus.ctrl.deep_stop_select;
	assign ctl_xosc   = bus.ctrl.xosc_in_stop;
	assign lv_in_stop = ctl_low_volt_detect_enable & ctl_lvse;
	assign pin_reset  = ~rpin_sync;
	// programmed polarity applies outside deep stop only
	assign irq_asserted = (mode == st_deep) ? ~irq_sync :
	                      (bus.ctrl.irq_active_high ? irq_sync : ~irq_sync);
	assign wake_deep  = pin_reset | irq_asserted | rti_wakeup;
	assign wake_light = irq_asserted | rti_wakeup;

	// mode state machine and its outputs
	dss_mode_t               next_mode;
	logic                    next_illegal;
	logic                    next_restart;
	logic                    next_core;
	logic                    next_periph;
	logic                    next_reg_sb;
	logic                    next_adc_sb;
	logic                    next_clkgen;
	logic                    next_xosc;
	logic                    next_lvd;

	always_comb begin
		next_mode    = mode;
		next_illegal = 1'b0;
		case (mode)
			st_run: begin
				if (pin_reset) begin
					next_mode = st_wake;
				end else if (stop_instr) begin
					if (!ctl_allow) begin
						next_illegal = 1'b1;
					end else if (lv_in_stop) begin
						next_mode = st_light;
					end else if (ctl_deep) begin
						next_mode = st_deep;
					end else begin
						next_mode = st_light;
					end
				end
			end
			st_light: begin
				if (pin_reset) begin
					next_mode = st_wake;
				end else if (wake_light) begin
					next_mode = st_run;
				end
			end
			st_deep: begin
				if (wake_deep) begin
					next_mode = st_wake;
				end
			end
			st_wake: next_mode = st_run;
			default: next_mode = st_run;
		endcase
		next_restart = (next_mode == st_wake);
		next_core    = (next_mode != st_deep);
		next_periph  = (next_mode != st_deep);
		next_reg_sb  = (next_mode == st_deep) | (next_mode == st_light);
		next_adc_sb  = (next_mode == st_deep) | ((next_mode == st_light) & ~lv_in_stop);
		next_clkgen  = (next_mode == st_run) | (next_mode == st_wake);
		next_xosc    = next_clkgen | ((next_mode == st_light) & ctl_xosc);
		next_lvd     = ctl_low_volt_detect_enable & (next_clkgen | ((next_mode == st_light) & ctl_lvse));
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mode              <= st_run;
			illegal_reset     <= 1'b0;
			sys_restart       <= 1'b0;
			core_power_on     <= 1'b1;
			periph_power_on   <= 1'b1;
			ram_power_on      <= 1'b1;
			regulator_standby <= 1'b0;
			adc_standby       <= 1'b0;
			clkgen_on         <= 1'b1;
			xosc_on           <= 1'b1;
			lvd_active        <= 1'b0;
			irq_pullup_on     <= 1'b0;
		end else begin
			mode              <= next_mode;
			illegal_reset     <= next_illegal;
			sys_restart       <= next_restart;
			core_power_on     <= next_core;
			periph_power_on   <= next_periph;
			ram_power_on      <= 1'b1;
			regulator_standby <= next_reg_sb;
			adc_standby       <= next_adc_sb;
			clkgen_on         <= next_clkgen;
			xosc_on           <= next_xosc;
			lvd_active        <= next_lvd;
			irq_pullup_on     <= bus.ctrl.irq_pullup_enable;
		end
	end

	// both restart kinds return the settings to default
	assign bus.soft_rst = sys_restart | illegal_reset;

	// pin latch: survives restart, opened only by the release ack
	logic                    next_hold;
	logic [`DSS_PORT_W-1:0]  pin_latch;
	logic [`DSS_PORT_W-1:0]  next_latch;
	logic [`DSS_PORT_W-1:0]  next_pins;
	logic                    woke_deep;
	logic                    next_woke;
	logic                    deep_entry;

	always_comb begin
		deep_entry = (next_mode == st_deep) & (mode != st_deep);
		next_hold  = pin_hold;
		next_latch = pin_latch;
		next_woke  = woke_deep;
		if (bus.ack_pulse) begin
			next_hold = 1'b0;
			next_woke = 1'b0;
		end
		// entry wins over a coincident ack
		if (deep_entry) begin
			next_hold  = 1'b1;
			// a second entry while held keeps the pins already frozen
			next_latch = pin_hold ? pin_latch : bus.port_reg;
		end
		if ((mode == st_deep) & (next_mode == st_wake)) begin
			next_woke = 1'b1;
		end
		next_pins = next_hold ? next_latch : bus.port_reg;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pin_hold  <= 1'b0;
			pin_latch <= `DSS_PORT_RST;
			woke_deep <= 1'b0;
			port_pins <= `DSS_PORT_RST;
		end else begin
			pin_hold  <= next_hold;
			pin_latch <= next_latch;
			woke_deep <= next_woke;
			port_pins <= next_pins;
		end
	end

	assign bus.status = {woke_deep, (mode == st_light), (mode == st_deep), pin_hold};

	a_illegal_no_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode == st_run) && !pin_reset && stop_instr && !ctl_allow |=> illegal_reset && (mode == st_run))
		else $error("stop while not allowed did not give illegal reset");

	a_deep_entry_ok: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode == st_run) && !pin_reset && stop_instr && ctl_allow && ctl_deep && !lv_in_stop
		|=> (mode == st_deep) && pin_hold)
		else $error("deep stop not entered");

	a_lv_forces_light: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode == st_run) && !pin_reset && stop_instr && ctl_allow && lv_in_stop |=> (mode == st_light))
		else $error("detector in stop did not force light stop");

	a_deep_power_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode == st_deep) |-> !core_power_on && !periph_power_on && ram_power_on
		&& regulator_standby && adc_standby && !clkgen_on)
		else $error("wrong power state in deep stop");

	a_hold_until_ack: assert property (@(posedge ref_clk) disable iff (!rst_n)
		pin_hold && !bus.ack_pulse |=> pin_hold)
		else $error("pin hold dropped without ack");

	a_deep_no_wake: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode == st_deep) && !pin_reset && irq_sync && !rti_wakeup |=> (mode == st_deep))
		else $error("deep stop left without a wake source");

	a_irq_low_wakes: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode == st_deep) && !irq_sync |=> (mode == st_wake) ##1 (mode == st_run))
		else $error("low interrupt pin did not wake deep stop");

	a_wake_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode == st_deep) && rti_wakeup |=> sys_restart && pin_hold ##1 !sys_restart && pin_hold)
		else $error("deep wake did not restart with pins held");

	a_light_clock_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode == st_light) && $past(mode == st_light) |-> !clkgen_on && (xosc_on == $past(ctl_xosc)))
		else $error("clock generator state wrong in light stop");

	a_lvd_stop_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode == st_light) |-> lvd_active == ($past(ctl_low_volt_detect_enable) && $past(ctl_lvse)))
		else $error("detector activity in stop wrong");

	a_pins_frozen: assert property (@(posedge ref_clk) disable iff (!rst_n)
		pin_hold && $past(pin_hold) |-> $stable(port_pins))
		else $error("pins moved while held");

	a_illegal_clears_regs: assert property (@(posedge ref_clk) disable iff (!rst_n)
		illegal_reset |=> (bus.ctrl == dss_ctrl_t'(`DSS_CTRL_RST)) && (bus.port_reg == `DSS_PORT_RST))
		else $error("illegal reset did not clear the settings");

	a_stop_modes_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode == st_run) && !pin_reset && stop_instr && ctl_allow
		|=> !illegal_reset && ((mode == st_light) || (mode == st_deep)))
		else $error("allowed stop did not reach a stop mode");

	a_plain_light: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode == st_run) && !pin_reset && stop_instr && ctl_allow && !ctl_deep && !lv_in_stop
		|=> (mode == st_light))
		else $error("stop without deep select did not give light stop");

	a_light_power_state: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode == st_light) |-> core_power_on && periph_power_on && regulator_standby && !clkgen_on)
		else $error("wrong power state in light stop");

	a_run_power_state: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode == st_run) |-> core_power_on && periph_power_on && ram_power_on && clkgen_on
		&& !regulator_standby && !adc_standby)
		else $error("wrong power state in run");

	a_deep_lvd_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode == st_deep) |-> !lvd_active)
		else $error("detector active in deep stop");

	a_hold_on_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(pin_hold) |-> (mode == st_deep))
		else $error("pins latched outside deep stop entry");

	a_ack_releases: assert property (@(posedge ref_clk) disable iff (!rst_n)
		pin_hold && bus.ack_pulse && !deep_entry |=> !pin_hold)
		else $error("release ack did not open the pin latch");

	a_reset_pin_wakes: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode == st_deep) && pin_reset |=> (mode == st_wake) && sys_restart)
		else $error("reset pin did not wake deep stop");

	a_irq_polarity_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode == st_deep) && !irq_sync && bus.ctrl.irq_active_high |=> (mode == st_wake))
		else $error("programmed polarity blocked a low interrupt pin in deep stop");

	a_restart_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
		sys_restart |=> (bus.ctrl == dss_ctrl_t'(`DSS_CTRL_RST)) && (bus.port_reg == `DSS_PORT_RST))
		else $error("restart did not return the settings to default");

	a_held_pins_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
		pin_hold |-> (port_pins == pin_latch))
		else $error("held pins differ from the latch");

	a_free_pins_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!pin_hold |-> (port_pins == $past(bus.port_reg)))
		else $error("free pins do not follow the port register");

	a_no_auto_pullup: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode == st_deep) |-> (irq_pullup_on == $past(bus.ctrl.irq_pullup_enable)))
		else $error("interrupt pull-up changed by itself in deep stop");
endmodule

`default_nettype wire

// ---- verif/deep_stop_mode_sequencer_bench.sv ----
// self-checking bench for the deep stop sequencer
`timescale 1ns/1ns
`default_nettype none
`include "dss_params.svh"

module deep_stop_mode_sequencer_bench;
	import dss_pkg::*;
	logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, lfsr;
	logic        stop_instr, reset_pin_n, irq_pin, rti_wakeup, illegal_reset, sys_restart;
	logic        core_power_on, periph_power_on, ram_power_on, regulator_standby, adc_standby;
	logic        clkgen_on, xosc_on, lvd_active, irq_pullup_on, pin_hold;
	logic [7:0]  port_pins, v;
	dss_mode_t   mode;
	int          bad_count, n_tests, k;

	dss_sequencer DUT (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .stop_instr, .reset_pin_n, .irq_pin, .rti_wakeup, .mode, .illegal_reset, .sys_restart,
		.core_power_on, .periph_power_on, .ram_power_on, .regulator_standby, .adc_standby, .clkgen_on,
		.xosc_on, .lvd_active, .irq_pullup_on, .pin_hold, .port_pins);

	dss_core_model model (.ref_clk, .stop_instr, .reset_pin_n, .irq_pin, .rti_wakeup);

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [31:0] exp_status(input logic hold, input logic deep, input logic light,
		input logic woke);
		return {28'h000_0000, woke, light, deep, hold};
	endfunction

	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// master holds the request until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask

	task automatic wait_mode(input dss_mode_t m);
		for (int i = 0; i < 12 && mode !== m; i++) begin
			@(posedge ref_clk);
			#1;
		end
	endtask

	task automatic stop_test();
		$display("counts: %0d compares, %0d mismatches", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#20000;
		bad_count++;
		stop_test();
	end

	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		lfsr = 32'h2ca9_a750;
		bad_count = 0;
		n_tests = 0;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		apb(1'b0, `DSS_OFS_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		chk(mode, st_run);
		apb(1'b0, 12'h010, 32'h0000_0000);
		chk({err, rd}, {1'b1, 32'h0000_0000});
		apb(1'b1, `DSS_OFS_STATUS, 32'h0000_000f);
		apb(1'b0, `DSS_OFS_STATUS, 32'h0000_0000);
		chk({err, rd}, {1'b0, exp_status(0, 0, 0, 0)});
		$display("test registers done");
		// deep select without stop allowed must not stop
		apb(1'b1, `DSS_OFS_CTRL, 32'h0000_0068);
		model.exec_stop();
		#1;
		chk({illegal_reset, mode}, {1'b1, st_run});
		apb(1'b0, `DSS_OFS_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		$display("test illegal stop done");
		// detector active in stop overrides deep select
		apb(1'b1, `DSS_OFS_CTRL, 32'h0000_001f);
		model.exec_stop();
		#1;
		chk(mode, st_light);
		chk(lvd_active, 1'b1);
		chk({clkgen_on, xosc_on, core_power_on, pin_hold}, 4'b0110);
		model.wake(1, 1'b1);
		wait_mode(st_run);
		chk({mode, sys_restart}, {st_run, 1'b0});
		model.wake(1, 1'b0);
		$display("test light stop done");
		// stop allowed with neither deep select nor detector in stop
		apb(1'b1, `DSS_OFS_CTRL, 32'h0000_0001);
		model.exec_stop();
		#1;
		chk({mode, xosc_on, adc_standby, lvd_active}, {st_light, 3'b010});
		model.wake(0, 1'b1);
		wait_mode(st_run);
		chk({mode, sys_restart}, {st_run, 1'b0});
		model.wake(0, 1'b0);
		$display("test plain light stop done");
		for (k = 0; k < 3; k++) begin
			lfsr = next_rand(lfsr);
			v = lfsr[7:0];
			apb(1'b1, `DSS_OFS_PORT, {24'h00_0000, v});
			apb(1'b1, `DSS_OFS_CTRL, 32'h0000_0069);
			model.exec_stop();
			#1;
			chk(mode, st_deep);
			chk({core_power_on, periph_power_on, ram_power_on, regulator_standby, adc_standby}, 5'b00111);
			chk({clkgen_on, lvd_active, irq_pullup_on}, 3'b001);
			chk({pin_hold, port_pins}, {1'b1, v});
			apb(1'b1, `DSS_OFS_PORT, {24'h00_0000, ~v});
			chk(port_pins, v);
			model.wake(k, 1'b1);
			wait_mode(st_wake);
			chk({mode, sys_restart}, {st_wake, 1'b1});
			model.wake(k, 1'b0);
			repeat (6) @(posedge ref_clk);
			apb(1'b0, `DSS_OFS_CTRL, 32'h0000_0000);
			chk({mode, rd}, {st_run, 32'h0000_0000});
			chk({pin_hold, port_pins}, {1'b1, v});
			apb(1'b0, `DSS_OFS_STATUS, 32'h0000_0000);
			chk(rd, exp_status(1, 0, 0, 1));
			lfsr = next_rand(lfsr);
			v = lfsr[7:0];
			apb(1'b1, `DSS_OFS_PORT, {24'h00_0000, v});
			apb(1'b1, `DSS_OFS_ACK, 32'h0000_0001);
			repeat (2) @(posedge ref_clk);
			#1;
			chk({pin_hold, port_pins}, {1'b0, v});
			$display("test deep stop wake source %0d done", k);
		end
		stop_test();
	end
endmodule

`default_nettype wire

// ---- verif/dss_core_model.sv ----
// model of the processor core and the wake-up pins facing the stop sequencer
`timescale 1ns/1ns
`default_nettype none

module dss_core_model (
	input  wire logic ref_clk,
	output logic      stop_instr,
	output logic      reset_pin_n,
	output logic      irq_pin,
	output logic      rti_wakeup
);
	// board pull-up keeps the irq line high while nobody pulls it down
	initial begin
		stop_instr  = 1'b0;
		reset_pin_n = 1'b1;
		irq_pin     = 1'b1;
		rti_wakeup  = 1'b0;
	end

	// stop instruction lasts exactly one core cycle
	task automatic exec_stop();
		@(posedge ref_clk);
		stop_instr <= 1'b1;
		@(posedge ref_clk);
		stop_instr <= 1'b0;
	endtask

	// k: 0 wake-up timer, 1 irq pin, 2 reset pin
	task automatic wake(input int k, input logic on);
		@(posedge ref_clk);
		case (k)
			0: rti_wakeup <= on;
			1: irq_pin <= !on;
			default: reset_pin_n <= !on;
		endcase
	endtask
endmodule

`default_nettype wire
